// ===== verilog/dscr_defs.vh
// Purpose: shared constants for the status and control word bank
// Assumes: included by bare name from the design files
// Notes: field positions, reset values, bit-op selector codes
`ifndef DSCR_DEFS_VH
`define DSCR_DEFS_VH

// ==================================================
// status word zero fields
`define DSCR_ST0_ARP_HI 15
`define DSCR_ST0_ARP_LO 13
`define DSCR_ST0_OV 12
`define DSCR_ST0_OVM 11
`define DSCR_ST0_ONE 10
`define DSCR_ST0_GLOBAL_IRQ_DISABLE 9
`define DSCR_ST0_DP_HI 8
`define DSCR_ST0_DP_LO 0

// ==================================================
// status word one fields
`define DSCR_ST1_ARB_HI 15
`define DSCR_ST1_ARB_LO 13
`define DSCR_ST1_CNF 12
`define DSCR_ST1_TC 11
`define DSCR_ST1_SXM 10
`define DSCR_ST1_C 9
`define DSCR_ST1_XF 4
`define DSCR_ST1_PM_HI 1
`define DSCR_ST1_PM_LO 0

// reserved positions read as one
`define DSCR_ST0_RSVD 16'h0400
`define DSCR_ST1_RSVD 16'h01EC

// ==================================================
// reset values of the individual fields
`define DSCR_RST_ARP 3'h0
`define DSCR_RST_ARB 3'h0
`define DSCR_RST_OV 1'b0
`define DSCR_RST_OVM 1'b0
`define DSCR_RST_GLOBAL_IRQ_DISABLE 1'b1
`define DSCR_RST_DP 9'h000
`define DSCR_RST_CNF 1'b0
`define DSCR_RST_TC 1'b0
`define DSCR_RST_SXM 1'b1
`define DSCR_RST_C 1'b1
`define DSCR_RST_XF 1'b1
`define DSCR_RST_PM 2'h0

// ==================================================
// single-bit set/clear selector codes
`define DSCR_BIT_OVM 3'h0
`define DSCR_BIT_GLOBAL_IRQ_DISABLE 3'h1
`define DSCR_BIT_CNF 3'h2
`define DSCR_BIT_TC 3'h3
`define DSCR_BIT_SXM 3'h4
`define DSCR_BIT_C 3'h5
`define DSCR_BIT_XF 3'h6

// product shift modes
`define DSCR_PM_NONE 2'h0
`define DSCR_PM_L1 2'h1
`define DSCR_PM_L4 2'h2
`define DSCR_PM_R6 2'h3

`endif

// ===== verilog/dscr_pscale.v
// Purpose: product scaling shifter on the path from product register to alu
// Assumes: product_reg is held outside and never altered here
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
`include "dscr_defs.vh"

module dscr_pscale #(
	parameter PW = 32
) (
	product_shift_sel,
	product_reg,
	scaled
);
	input wire [1:0] product_shift_sel;
	input wire [PW-1:0] product_reg;
	output reg [PW-1:0] scaled;

	// ==================================================
	// shift select
	always @* begin
		case (product_shift_sel)
			`DSCR_PM_NONE: begin
				scaled = product_reg;
			end
			`DSCR_PM_L1: begin
				scaled = {product_reg[PW-2:0], 1'b0};
			end
			`DSCR_PM_L4: begin
				scaled = {product_reg[PW-5:0], 4'h0};
			end
			`DSCR_PM_R6: begin
				scaled = {{6{product_reg[PW-1]}}, product_reg[PW-1:6]};
			end
			default: begin
				scaled = product_reg;
			end
		endcase
	end
endmodule

// ===== verilog/dscr_regs.v
// Purpose: processor status words zero and one with their update logic
// Assumes: one core instruction event per cycle; all inputs synchronous to clk
// Notes: store-status reads the registered words; reserved bits are constants
`timescale 1ns/1ps
`include "dscr_defs.vh"

module dscr_regs #(
	parameter PW = 32
) (
	input wire clk,
	input wire rst,
	input wire load_status_instr,
	input wire load_status_word,
	input wire [15:0] load_status_data,
	output wire [15:0] status_word_zero,
	output wire [15:0] status_word_one,
	input wire bit_set_instr,
	input wire bit_clear_instr,
	input wire [2:0] bit_sel,
	input wire arp_load_en,
	input wire [2:0] arp_load_val,
	input wire load_page_instr,
	input wire [8:0] load_page_val,
	input wire [6:0] instr_low_bits,
	output wire [15:0] direct_addr,
	input wire set_shift_instr,
	input wire [1:0] set_shift_val,
	input wire alu_add,
	input wire alu_sub,
	input wire alu_shift16,
	input wire alu_carry_out,
	input wire alu_borrow,
	input wire shift_carry_en,
	input wire shift_carry_val,
	input wire alu_overflow,
	input wire cond_branch_instr,
	input wire cond_branch_on_ov,
	input wire trap_taken,
	input wire maskable_irq_req,
	output wire maskable_irq_ok,
	input wire bit_test_en,
	input wire bit_test_val,
	input wire aux_compare_instr,
	input wire aux_compare_true,
	input wire left_justify_instr,
	input wire [1:0] acc_msbs,
	input wire add_no_extend_instr,
	output wire sign_extend_active,
	output wire [2:0] aux_reg_pointer,
	output wire saturate_mode_sel,
	output wire ram_space_select,
	output wire test_cond_flag,
	output wire carry_flag,
	output wire arith_wrap_flag,
	output wire global_irq_disable,
	output wire external_flag_pin,
	input wire [PW-1:0] product_reg,
	output wire [PW-1:0] scaled_product
);

	// ==================================================
	// state
	reg [2:0] arp_ff;
	reg [2:0] nxt_arp;
	reg [2:0] arb_ff;
	reg [2:0] nxt_arb;
	reg ov_ff;
	reg nxt_ov;
	reg ovm_ff;
	reg nxt_ovm;
	reg global_irq_disable_ff;
	reg nxt_global_irq_disable;
	reg [8:0] dp_ff;
	reg [8:0] nxt_dp;
	reg cnf_ff;
	reg nxt_cnf;
	reg tc_ff;
	reg nxt_tc;
	reg sxm_ff;
	reg nxt_sxm;
	reg c_ff;
	reg nxt_c;
	reg xf_ff;
	reg nxt_xf;
	reg [1:0] pm_ff;
	reg [1:0] nxt_pm;
	reg [PW-1:0] scaled_ff;
	wire [PW-1:0] scaled_comb;
	wire lst0;
	wire lst1;
	wire bit_op;

	// one decode shared by every bit-addressed flag
	function bit_hit;
		input op;
		input [2:0] sel;
		input [2:0] code;
		begin
			bit_hit = op && (sel == code);
		end
	endfunction

	assign lst0 = load_status_instr && !load_status_word;
	assign lst1 = load_status_instr && load_status_word;
	assign bit_op = bit_set_instr || bit_clear_instr;

	// ==================================================
	// next-state logic
	always @* begin
		nxt_arp = arp_ff;
		nxt_arb = arb_ff;
		nxt_ov = ov_ff;
		nxt_ovm = ovm_ff;
		nxt_global_irq_disable = global_irq_disable_ff;
		nxt_dp = dp_ff;
		nxt_cnf = cnf_ff;
		nxt_tc = tc_ff;
		nxt_sxm = sxm_ff;
		nxt_c = c_ff;
		nxt_xf = xf_ff;
		nxt_pm = pm_ff;

		if (lst0) begin
			nxt_arp = load_status_data[`DSCR_ST0_ARP_HI:`DSCR_ST0_ARP_LO];
		end else if (lst1) begin
			nxt_arb = load_status_data[`DSCR_ST1_ARB_HI:`DSCR_ST1_ARB_LO];
			nxt_arp = load_status_data[`DSCR_ST1_ARB_HI:`DSCR_ST1_ARB_LO];
		end else if (arp_load_en) begin
			nxt_arp = arp_load_val;
			nxt_arb = arp_ff;
		end

		// clears first, so a same-cycle overflow still latches
		if (lst0) begin
			nxt_ov = load_status_data[`DSCR_ST0_OV];
		end else if (cond_branch_instr && cond_branch_on_ov) begin
			nxt_ov = 1'b0;
		end
		if (alu_overflow) begin
			nxt_ov = 1'b1;
		end

		if (lst0) begin
			nxt_ovm = load_status_data[`DSCR_ST0_OVM];
			nxt_dp = load_status_data[`DSCR_ST0_DP_HI:`DSCR_ST0_DP_LO];
		end else if (load_page_instr) begin
			nxt_dp = load_page_val;
		end

		if (lst1) begin
			nxt_cnf = load_status_data[`DSCR_ST1_CNF];
			nxt_tc = load_status_data[`DSCR_ST1_TC];
			nxt_sxm = load_status_data[`DSCR_ST1_SXM];
			nxt_c = load_status_data[`DSCR_ST1_C];
			nxt_pm = load_status_data[`DSCR_ST1_PM_HI:`DSCR_ST1_PM_LO];
			nxt_xf = load_status_data[`DSCR_ST1_XF];
		end else if (set_shift_instr) begin
			nxt_pm = set_shift_val;
		end

		if (bit_test_en) begin
			nxt_tc = bit_test_val;
		end else if (aux_compare_instr) begin
			nxt_tc = aux_compare_true;
		end else if (left_justify_instr) begin
			nxt_tc = acc_msbs[1] ^ acc_msbs[0];
		end

		if (alu_add) begin
			if (alu_shift16) begin
				if (alu_carry_out) begin
					nxt_c = 1'b1;
				end
			end else begin
				nxt_c = alu_carry_out;
			end
		end else if (alu_sub) begin
			if (alu_shift16) begin
				if (alu_borrow) begin
					nxt_c = 1'b0;
				end
			end else begin
				nxt_c = !alu_borrow;
			end
		end else if (shift_carry_en) begin
			nxt_c = shift_carry_val;
		end

		if (bit_hit(bit_op, bit_sel, `DSCR_BIT_OVM)) begin
			nxt_ovm = bit_set_instr;
		end
		if (bit_hit(bit_op, bit_sel, `DSCR_BIT_GLOBAL_IRQ_DISABLE)) begin
			nxt_global_irq_disable = bit_set_instr;
		end
		if (bit_hit(bit_op, bit_sel, `DSCR_BIT_CNF)) begin
			nxt_cnf = bit_set_instr;
		end
		if (bit_hit(bit_op, bit_sel, `DSCR_BIT_TC)) begin
			nxt_tc = bit_set_instr;
		end
		if (bit_hit(bit_op, bit_sel, `DSCR_BIT_SXM)) begin
			nxt_sxm = bit_set_instr;
		end
		if (bit_hit(bit_op, bit_sel, `DSCR_BIT_C)) begin
			nxt_c = bit_set_instr;
		end
		if (bit_hit(bit_op, bit_sel, `DSCR_BIT_XF)) begin
			nxt_xf = bit_set_instr;
		end

		// trap entry wins over a same-cycle clear
		if (trap_taken) begin
			nxt_global_irq_disable = 1'b1;
		end
	end

	// ==================================================
	// registers
	// reset values
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			arp_ff <= `DSCR_RST_ARP;
			arb_ff <= `DSCR_RST_ARB;
			ov_ff <= `DSCR_RST_OV;
			ovm_ff <= `DSCR_RST_OVM;
			global_irq_disable_ff <= `DSCR_RST_GLOBAL_IRQ_DISABLE;
			dp_ff <= `DSCR_RST_DP;
			cnf_ff <= `DSCR_RST_CNF;
			tc_ff <= `DSCR_RST_TC;
			sxm_ff <= `DSCR_RST_SXM;
			c_ff <= `DSCR_RST_C;
			xf_ff <= `DSCR_RST_XF;
			pm_ff <= `DSCR_RST_PM;
			scaled_ff <= {PW{1'b0}};
		end else begin
			arp_ff <= nxt_arp;
			arb_ff <= nxt_arb;
			ov_ff <= nxt_ov;
			ovm_ff <= nxt_ovm;
			global_irq_disable_ff <= nxt_global_irq_disable;
			dp_ff <= nxt_dp;
			cnf_ff <= nxt_cnf;
			tc_ff <= nxt_tc;
			sxm_ff <= nxt_sxm;
			c_ff <= nxt_c;
			xf_ff <= nxt_xf;
			pm_ff <= nxt_pm;
			scaled_ff <= scaled_comb;
		end
	end

	// ==================================================
	// status word assembly
	// reserved bits are constants, never stored
	assign status_word_zero = {arp_ff, ov_ff, ovm_ff, 1'b1, global_irq_disable_ff, dp_ff} | `DSCR_ST0_RSVD;
	assign status_word_one = {arb_ff, cnf_ff, tc_ff, sxm_ff, c_ff, 4'hF, xf_ff, 2'h3, pm_ff} | `DSCR_ST1_RSVD;

	assign direct_addr = {dp_ff, instr_low_bits};
	assign maskable_irq_ok = maskable_irq_req && !global_irq_disable_ff;
	assign sign_extend_active = sxm_ff && !add_no_extend_instr;

	assign aux_reg_pointer = arp_ff;
	// saturation mode exported to the accumulator
	assign saturate_mode_sel = ovm_ff;
	assign ram_space_select = cnf_ff;
	assign test_cond_flag = tc_ff;
	assign carry_flag = c_ff;
	assign arith_wrap_flag = ov_ff;
	assign global_irq_disable = global_irq_disable_ff;
	assign external_flag_pin = xf_ff;

	// ==================================================
	// product scaling, one cycle of latency
	// scaling leaves product_reg untouched
	dscr_pscale #(
		.PW(PW)
	) u_pscale (
		.product_shift_sel(pm_ff),
		.product_reg(product_reg),
		.scaled(scaled_comb)
	);
	assign scaled_product = scaled_ff;

endmodule

// ===== tb/dscr_regs_properties.sv
// Purpose: port-level relations of the status word bank
// Assumes: bound onto dscr_regs, one clock domain
// Notes: bit-op priority is excluded where it would override
`timescale 1ns/1ps
module dscr_regs_properties (
	input wire clk,
	input wire rst,
	input wire load_status_instr,
	input wire load_status_word,
	input wire bit_set_instr,
	input wire bit_clear_instr,
	input wire arp_load_en,
	input wire [2:0] arp_load_val,
	input wire alu_add,
	input wire alu_shift16,
	input wire alu_carry_out,
	input wire alu_overflow,
	input wire trap_taken,
	input wire maskable_irq_req,
	input wire maskable_irq_ok,
	input wire [6:0] instr_low_bits,
	input wire [15:0] direct_addr,
	input wire [15:0] status_word_zero,
	input wire [15:0] status_word_one,
	input wire [2:0] aux_reg_pointer,
	input wire carry_flag,
	input wire arith_wrap_flag,
	input wire global_irq_disable
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire bop = bit_set_instr | bit_clear_instr;
	sequence arp_step;
		arp_load_en && !load_status_instr;
	endsequence
	sequence lst_one;
		load_status_instr && load_status_word;
	endsequence
	rsvd_zero_a: assert property (status_word_zero[10]) else $error("word zero spare bit low");
	rsvd_one_a: assert property ((status_word_one & 16'h01EC) == 16'h01EC) else $error("word one spare low");
	irq_hold_a: assert property (load_status_instr && !trap_taken && !bop |=> $stable(global_irq_disable))
		else $error("irq disable moved on load");
	arp_buf_a: assert property (arp_step |=> aux_reg_pointer == $past(arp_load_val)
		&& status_word_one[15:13] == $past(aux_reg_pointer)) else $error("pointer buffer wrong");
	lst_copy_a: assert property (lst_one |=> aux_reg_pointer == status_word_one[15:13])
		else $error("pointer not copied");
	page_addr_a: assert property (direct_addr == {status_word_zero[8:0], instr_low_bits})
		else $error("direct address wrong");
	add_carry_a: assert property (alu_add && !alu_shift16 && !bop |=> carry_flag == $past(alu_carry_out))
		else $error("add carry wrong");
	trap_irq_a: assert property (trap_taken |=> global_irq_disable) else $error("trap left irq open");
	ov_latch_a: assert property (alu_overflow |=> arith_wrap_flag) else $error("overflow not latched");
	irq_gate_a: assert property (maskable_irq_ok == (maskable_irq_req && !global_irq_disable))
		else $error("irq gate wrong");
	mirror_a: assert property (status_word_one[9] == carry_flag && status_word_zero[12] == arith_wrap_flag)
		else $error("word fields differ from flags");
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench for the status word bank
// Assumes: one event per cycle, inputs driven 1 ns after the edge
// Notes: random data from a fixed seed
`timescale 1ns/1ps
module testbench;
	logic clk, rst, load_status_instr, load_status_word, bit_set_instr, bit_clear_instr, arp_load_en;
	logic load_page_instr, set_shift_instr, alu_add, alu_sub, alu_shift16, alu_carry_out, alu_borrow;
	logic shift_carry_en, shift_carry_val, alu_overflow, cond_branch_instr, cond_branch_on_ov, trap_taken;
	logic maskable_irq_req, bit_test_en, bit_test_val, aux_compare_instr, aux_compare_true;
	logic left_justify_instr, add_no_extend_instr, maskable_irq_ok, sign_extend_active;
	logic saturate_mode_sel, ram_space_select, test_cond_flag, carry_flag, arith_wrap_flag;
	logic global_irq_disable, external_flag_pin;
	logic [15:0] load_status_data, status_word_zero, status_word_one, direct_addr, d;
	logic [2:0] bit_sel, arp_load_val, aux_reg_pointer, v;
	logic [8:0] load_page_val;
	logic [6:0] instr_low_bits;
	logic [1:0] set_shift_val, acc_msbs;
	logic [31:0] product_reg, scaled_product, w, p;
	logic c;
	int n_fail, total_checks, i;
	int pos[7] = '{27, 25, 12, 11, 10, 9, 4};
	dscr_regs #(.PW(32)) dscr_regs_inst (.*);
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task clr;
		{load_status_instr, bit_set_instr, bit_clear_instr, arp_load_en, load_page_instr, set_shift_instr,
			alu_add, alu_sub, alu_shift16, alu_carry_out, alu_borrow, shift_carry_en, alu_overflow,
			cond_branch_instr, trap_taken, bit_test_en, aux_compare_instr, left_justify_instr} = '0;
		maskable_irq_req = 1'($urandom);
	endtask
	task tick;
		@(posedge clk);
		#1;
		clr();
	endtask
	task bop(input logic s, input logic [2:0] b);
		bit_set_instr = s;
		bit_clear_instr = !s;
		bit_sel = b;
		tick();
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (e !== s) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	function logic cexp(input logic ad, input logic s16, input logic co, input logic bo, input logic cin);
		if (ad)
			return s16 ? (cin | co) : co;
		return s16 ? (cin & ~bo) : ~bo;
	endfunction
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		n_fail = 0;
		total_checks = 0;
		i = $urandom(49);
		{rst, load_status_word, cond_branch_on_ov, bit_test_val, aux_compare_true, add_no_extend_instr} = 6'h2E;
		{load_status_data, bit_sel, arp_load_val, load_page_val, instr_low_bits} = '0;
		{set_shift_val, acc_msbs, product_reg, shift_carry_val} = '0;
		clr();
		repeat (12) @(posedge clk);
		#1 rst = 0;
		chk("word0", 16'h0600, status_word_zero);
		chk("word1", 16'h07FC, status_word_one);
		for (i = 0; i < 14; i++) begin
			w = {status_word_zero, status_word_one};
			w[pos[i >> 1]] = i[0];
			bop(i[0], 3'(i >> 1));
			chk("bitop", w, {status_word_zero, status_word_one});
			chk("pins", {w[27], w[12], w[4]}, {saturate_mode_sel, ram_space_select, external_flag_pin});
		end
		bop(1, 7);
		chk("sel7", w, {status_word_zero, status_word_one});
		for (i = 0; i < 20; i++) begin
			d = 16'($urandom);
			w = {status_word_zero, status_word_one};
			{load_status_instr, load_status_word, load_status_data} = {1'b1, i[0], d};
			tick();
			if (i[0])
				chk("lst1", {d[15:13], d[12:0] | 13'h01EC}, status_word_one);
			else
				chk("lst0", {d[15:11], 1'b1, w[25], d[8:0]}, status_word_zero);
			chk("ptr", d[15:13], aux_reg_pointer);
			v = 3'($urandom);
			d = 16'(aux_reg_pointer);
			{arp_load_en, arp_load_val} = {1'b1, v};
			tick();
			chk("arb", {d[2:0], v}, {status_word_one[15:13], aux_reg_pointer});
		end
		{load_page_instr, load_page_val, instr_low_bits} = {1'b1, 16'($urandom)};
		tick();
		chk("page", {load_page_val, instr_low_bits}, direct_addr);
		for (i = 0; i < 8; i++) begin
			c = 1'($urandom);
			bop(c, 5);
			{alu_add, alu_sub, alu_carry_out, alu_borrow, alu_shift16} = {i[0], !i[0], i[1], i[1], i[2]};
			tick();
			chk("carry", cexp(i[0], i[2], i[1], i[1], c), carry_flag);
			{shift_carry_en, shift_carry_val} = {1'b1, !carry_flag};
			tick();
			chk("shc", shift_carry_val, carry_flag);
		end
		cond_branch_instr = 1;
		tick();
		chk("ov0", 0, arith_wrap_flag);
		alu_overflow = 1;
		tick();
		tick();
		chk("ov", 1, arith_wrap_flag);
		cond_branch_instr = 1;
		tick();
		chk("ovclr", 0, arith_wrap_flag);
		bop(0, 1);
		#1 maskable_irq_req = 1;
		#1 chk("irqok", 1, maskable_irq_ok);
		// trap and a clear in the same cycle: the trap must win
		trap_taken = 1;
		bop(0, 1);
		chk("trap", 1, global_irq_disable);
		#1 maskable_irq_req = 1;
		#1 chk("irqmask", 0, maskable_irq_ok);
		for (i = 0; i < 3; i++) begin
			bop(0, 3);
			{left_justify_instr, aux_compare_instr, bit_test_en} = 3'(1 << i);
			acc_msbs = 2'b01;
			tick();
			chk("tc", 1, test_cond_flag);
		end
		bop(1, 4);
		add_no_extend_instr = 1;
		#1 chk("noext", 0, sign_extend_active);
		add_no_extend_instr = 0;
		#1 chk("ext", 1, sign_extend_active);
		for (i = 0; i < 4; i++) begin
			p = $urandom;
			{set_shift_instr, set_shift_val, product_reg} = {1'b1, 2'(i), p};
			tick();
			tick();
			w = (i == 0) ? p : (i == 1) ? p << 1 : (i == 2) ? p << 4 : 32'($signed(p) >>> 6);
			chk("pscale", w, scaled_product);
			chk("pm", i, status_word_one[1:0]);
		end
		finish_test();
	end
endmodule
bind dscr_regs dscr_regs_properties dscr_regs_properties_inst (.*);
